// [tb/entry_checker_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module entry_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire irq_entry_pkg::irq_req_s req,
  input wire irq_entry_pkg::irq_res_s res
);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  logic hit;
  logic clean;
  // Present request whose reserved and mode bits are all clear
  assign hit = req.valid & req.entry_lo[0];
  assign clean = ~|{req.entry_lo[37:24], req.entry_lo[15:12], req.entry_lo[7:2]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  AST_RES_PULSE: assert property (req.valid |=> res.valid)
    else $error("result missing");
  AST_ABSENT_BLOCK: assert property (req.valid && !req.entry_lo[0] |=>
    res.action == irq_entry_pkg::ACT_BLOCK && res.desc_addr == 64'h0 && res.vector == 8'h00)
    else $error("absent entry not blocked");
  AST_ABSENT_FAULT: assert property (req.valid && !req.entry_lo[0] |=>
    res.fault == !$past(req.entry_lo[1]))
    else $error("absent fault flag wrong");
  AST_LOW_ADDR: assert property (hit && clean |=>
    res.desc_addr[31:0] == {$past(req.entry_lo[63:38]), 6'h00})
    else $error("low address wrong");
  AST_VECTOR: assert property (hit && clean |=>
    res.vector == $past(req.entry_lo[23:16]) && res.action == irq_entry_pkg::ACT_REMAP)
    else $error("vector or remap wrong");
  AST_CLEAN_NO_FAULT: assert property (hit && clean |=> !res.fault && !res.rsv_fault)
    else $error("fault on clean entry");
  AST_RSV_BLOCK: assert property (hit && |req.entry_lo[7:2] |=>
    res.action == irq_entry_pkg::ACT_BLOCK && res.rsv_fault)
    else $error("reserved bits not faulted");
  AST_URG_POST: assert property (res.valid && res.urgent |->
    res.action == irq_entry_pkg::ACT_POST)
    else $error("urgent without posting");
  // ------------------------------------------------
  // Covers
  // ------------------------------------------------
  cover property (res.valid && res.action == irq_entry_pkg::ACT_POST && res.urgent);
  cover property (res.valid && res.action == irq_entry_pkg::ACT_BLOCK && res.rsv_fault);
  cover property (res.valid && res.action == irq_entry_pkg::ACT_REMAP);
endmodule // entry_checker
`default_nettype wire

// [tb/entry_source.sv]
`timescale 1ns/10ps
`default_nettype none
module entry_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic dirty,
  input wire logic [63:0] lo,
  input wire logic [31:0] hi,
  output irq_entry_pkg::irq_req_s req
);
  // Reserved ranges of the low half
  localparam logic [63:0] RSV = 64'h0000_003f_ff00_30fc;
  // One request beat per go; idle lines flip so nothing stale is readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else if (go) begin
      req.valid <= 1'b1;
      req.entry_lo <= dirty ? lo : (lo & ~RSV);
      req.entry_hi <= hi; // pointer always names a whole 64-byte line
    end else begin
      req.valid <= 1'b0;
      req.entry_lo <= ~req.entry_lo;
      req.entry_hi <= ~req.entry_hi;
    end
  end
endmodule // entry_source
`default_nettype wire

// [tb/posted_irq_entry_decoder_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module posted_irq_entry_decoder_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, go, dirty, cap;
  logic [31:0] paddr, pwdata, prdata, hi, seed, exp_blk, exp_flt, q;
  logic [63:0] lo, l;
  logic [6:0] host_addr_width;
  logic [3:0] pstrb, exp_st;
  logic e;
  int n_fail, cmp_count;
  irq_entry_pkg::irq_req_s req;
  irq_entry_pkg::irq_res_s res;
  posted_irq_entry_decoder u_posted_irq_entry_decoder (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .res(res), .irq(irq));
  entry_source u_entry_source (.pclk(pclk), .presetn(presetn), .go(go), .dirty(dirty),
    .lo(lo), .hi(hi), .req(req));
  // ------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog bounds this wait
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, xe);
  endtask
  // Expected decode of one entry under the current capability and width
  function automatic irq_entry_pkg::irq_res_s exp_res(input logic [63:0] v, input logic [31:0] h);
    irq_entry_pkg::irq_res_s r;
    logic [31:0] m;
    r = '0;
    r.valid = 1'b1;
    for (int i = 0; i < 32; i++) m[i] = (i + 32 < host_addr_width);
    if (!v[0] || |{v[37:24], v[13:12], v[7:2]} || (!cap && |v[15:14])) begin
      r.action = irq_entry_pkg::ACT_BLOCK;
      r.fault = !v[1];
      r.rsv_fault = v[0];
    end else begin
      r.desc_addr = {h & m, v[63:38], 6'h00};
      r.vector = v[23:16];
      r.action = (v[15] && cap) ? irq_entry_pkg::ACT_POST : irq_entry_pkg::ACT_REMAP;
      r.urgent = v[15] & cap & v[14];
    end
    return r;
  endfunction
  // Present one entry through the source and compare the decode
  task automatic send(input logic [63:0] v, input logic d);
    irq_entry_pkg::irq_res_s x;
    @(posedge pclk);
    go <= 1'b1;
    lo <= v;
    hi <= $random(seed);
    dirty <= d;
    @(posedge pclk);
    go <= 1'b0;
    #1 x = exp_res(req.entry_lo, req.entry_hi);
    exp_blk += (x.action == irq_entry_pkg::ACT_BLOCK);
    exp_flt += x.fault;
    exp_st |= {x.fault, x.action == irq_entry_pkg::ACT_REMAP,
               x.action == irq_entry_pkg::ACT_POST, x.action == irq_entry_pkg::ACT_BLOCK};
    @(posedge pclk);
    #1 chk(res, x);
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, go, dirty} = '0;
    {paddr, pwdata, lo, hi, exp_blk, exp_flt} = '0;
    {n_fail, cmp_count} = '0;
    pstrb = 4'hf;
    exp_st = 4'h0;
    seed = 32'haef6c363;
    cap = 1'b1;
    host_addr_width = 7'h30;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(irq_entry_pkg::OFF_CTRL, 32'h0000_3001, 1'b0);
    rdc(irq_entry_pkg::OFF_MASK, 32'h0, 1'b0);
    rdc(32'h0000_0040, 32'h0, 1'b1);
    rdc(irq_entry_pkg::OFF_STATUS, 32'h0, 1'b0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      cap = (k != 1);
      host_addr_width = (k == 2) ? 7'h40 : (k == 3) ? 7'h20 : 7'h30;
      apb(1'b1, irq_entry_pkg::OFF_CTRL, {17'h0, host_addr_width, 7'h0, cap});
      rdc(irq_entry_pkg::OFF_CTRL, {17'h0, host_addr_width, 7'h0, cap}, 1'b0);
      for (int j = 0; j < 30; j++) begin
        l = {$random(seed), $random(seed)};
        if (j < 2) l[1:0] = {j[0], 1'b0};
        if (j == 2) l[0] = 1'b1;
        if (j == 3) l[15:14] = 2'b11;
        if (j == 4) l[15:14] = 2'b10;
        if (j == 3 || j == 4) l[0] = 1'b1;
        send(l, j == 2 || (j > 4 && ($random(seed) & 7) == 0));
      end
      $display("decode pass %0d done", k);
    end
    // Byte strobe: only the capability byte is taken, the width stays
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1'b1, irq_entry_pkg::OFF_CTRL, 32'h0000_3000);
    cap = 1'b0;
    pstrb <= 4'hf;
    rdc(irq_entry_pkg::OFF_CTRL, 32'h0000_2000, 1'b0);
    rdc(irq_entry_pkg::OFF_STATUS, {28'h0, exp_st}, 1'b0);
    apb(1'b1, irq_entry_pkg::OFF_MASK, 32'h1);
    send(64'h0, 1'b0);
    @(posedge pclk);
    #1 chk(irq, 1'b1);
    rdc(irq_entry_pkg::OFF_STATUS, 32'h9, 1'b0);
    @(posedge pclk);
    #1 chk(irq, 1'b0);
    send(64'h1, 1'b0);
    @(posedge pclk);
    #1 chk(irq, 1'b0);
    rdc(irq_entry_pkg::OFF_STATUS, 32'h4, 1'b0);
    rdc(irq_entry_pkg::OFF_BLOCK_CNT, exp_blk, 1'b0);
    rdc(irq_entry_pkg::OFF_FAULT_CNT, exp_flt, 1'b0);
    $display("interrupt test done");
    complete_run();
  end
endmodule // posted_irq_entry_decoder_bench
bind posted_irq_entry_decoder entry_checker u_entry_checker (.pclk(pclk), .presetn(presetn),
  .req(req), .res(res));
`default_nettype wire

// [verilog/entry_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module entry_decode (
  input wire irq_entry_pkg::irq_req_s req,
  input wire logic cap_post,
  input wire logic [6:0] host_addr_width,
  output irq_entry_pkg::irq_res_s res
);

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic present;
  logic fault_report_disable;
  logic mode_raw;
  logic urg_raw;
  logic mode;
  logic rsv_nz;
  logic [63:0] addr;

  // Present and fault-disable are read whatever the entry state
  assign present = req.entry_lo[irq_entry_pkg::PRES_BIT];
  assign fault_report_disable = req.entry_lo[irq_entry_pkg::FPD_BIT];
  assign mode_raw = req.entry_lo[irq_entry_pkg::MODE_BIT];
  assign urg_raw = req.entry_lo[irq_entry_pkg::URG_BIT];

  // Mode and urgency count as reserved without posting support
  assign mode = cap_post & mode_raw;

  // Reserved ranges; spare bits 11:8 never enter any term
  assign rsv_nz = (|req.entry_lo[irq_entry_pkg::RSV_A_HI:irq_entry_pkg::RSV_A_LO])
    | (|req.entry_lo[irq_entry_pkg::RSV_B_HI:irq_entry_pkg::RSV_B_LO])
    | (|req.entry_lo[irq_entry_pkg::RSV_C_HI:irq_entry_pkg::RSV_C_LO])
    | (~cap_post & (mode_raw | urg_raw));

  // Descriptor address, 64-byte aligned, upper bits cut at host width
  assign addr = {req.entry_hi & irq_entry_pkg::haw_upper_mask(host_addr_width),
    req.entry_lo[irq_entry_pkg::DPL_HI:irq_entry_pkg::DPL_LO],
    6'h00};

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  always_comb begin
    res = '0;
    res.valid = req.valid;
    if (!present) begin
      res.action = irq_entry_pkg::ACT_BLOCK;
      res.fault = ~fault_report_disable;
    end else if (rsv_nz) begin
      res.action = irq_entry_pkg::ACT_BLOCK;
      res.rsv_fault = 1'b1;
      res.fault = ~fault_report_disable;
    end else begin
      // Remaining fields only matter for a present entry
      res.desc_addr = addr;
      res.vector = req.entry_lo[irq_entry_pkg::VEC_HI:irq_entry_pkg::VEC_LO];
      if (mode) begin
        res.action = irq_entry_pkg::ACT_POST;
        res.urgent = urg_raw;
      end else begin
        res.action = irq_entry_pkg::ACT_REMAP;
      end
    end
  end

endmodule // entry_decode
`default_nettype wire

// [verilog/irq_entry_pkg.sv]
`default_nettype none
package irq_entry_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_FAULT_CNT = 8'h0c;
  localparam logic [7:0] OFF_ADDR_LO = 8'h10;
  localparam logic [7:0] OFF_ADDR_HI = 8'h14;
  localparam logic [7:0] OFF_INFO = 8'h18;
  localparam logic [7:0] OFF_BLOCK_CNT = 8'h1c;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CAP_BIT = 0;
  localparam int CTRL_HAW_LO = 8;
  localparam int HAW_W = 7;
  localparam logic CTRL_RST_CAP = 1'b1;
  localparam logic [6:0] CTRL_RST_HAW = 7'h30;

  // ----------------------------------------------------------------
  // Status and mask layout
  // ----------------------------------------------------------------
  localparam int ST_BLOCK = 0;
  localparam int ST_POST = 1;
  localparam int ST_REMAP = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_W = 4;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // Entry field positions, low 64-bit half
  // ----------------------------------------------------------------
  localparam int DPL_HI = 63;
  localparam int DPL_LO = 38;
  localparam int RSV_A_HI = 37;
  localparam int RSV_A_LO = 24;
  localparam int VEC_HI = 23;
  localparam int VEC_LO = 16;
  localparam int MODE_BIT = 15;
  localparam int URG_BIT = 14;
  localparam int RSV_B_HI = 13;
  localparam int RSV_B_LO = 12;
  localparam int SPARE_HI = 11;
  localparam int SPARE_LO = 8;
  localparam int RSV_C_HI = 7;
  localparam int RSV_C_LO = 2;
  localparam int FPD_BIT = 1;
  localparam int PRES_BIT = 0;
  localparam int DESC_ALIGN = 6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_BLOCK = 2'b01,
    ACT_POST = 2'b10,
    ACT_REMAP = 2'b11
  } action_e;

  typedef struct packed {
    logic valid;
    logic [63:0] entry_lo;
    logic [31:0] entry_hi;
  } irq_req_s;

  typedef struct packed {
    logic valid;
    action_e action;
    logic [63:0] desc_addr;
    logic [7:0] vector;
    logic urgent;
    logic fault;
    logic rsv_fault;
  } irq_res_s;

  // Keep mask for descriptor address bits 63:32 below the host width
  function automatic logic [31:0] haw_upper_mask(input logic [6:0] host_addr_width);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      m[i] = ((i + 32) < int'(host_addr_width));
    end
    return m;
  endfunction

endpackage
`default_nettype wire

// [verilog/posted_irq_entry_decoder.sv]
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module posted_irq_entry_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_entry_pkg::irq_req_s req,
  output irq_entry_pkg::irq_res_s res,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Merge write data into a register word by byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // True when the address hits a given word offset
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    return (a[31:8] == 24'h00_0000) && (a[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic cap_r;
  logic [6:0] haw_r;
  logic [3:0] status_r;
  logic [3:0] status_nxt;
  logic [3:0] mask_r;
  logic [15:0] fault_cnt_r;
  logic [15:0] block_cnt_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic [3:0] clr_bits_r;
  irq_entry_pkg::irq_res_s res_r;
  irq_entry_pkg::irq_res_s dec;
  logic setup;
  logic acc;
  logic wr;
  logic rd_status;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] mask_new;
  logic [3:0] ev;

  // ----------------------------------------------------------------
  // Entry decoding
  // ----------------------------------------------------------------

  // Combinational decode of the fetched entry
  entry_decode u_dec (
    .req(req),
    .cap_post(cap_r),
    .host_addr_width(haw_r),
    .res(dec)
  );

  // Result captured one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r <= '0;
    end else begin
      res_r <= dec;
    end
  end

  // Events raised by the current decode
  always_comb begin
    ev = 4'h0;
    if (dec.valid) begin
      ev[irq_entry_pkg::ST_BLOCK] = (dec.action == irq_entry_pkg::ACT_BLOCK);
      ev[irq_entry_pkg::ST_POST] = (dec.action == irq_entry_pkg::ACT_POST);
      ev[irq_entry_pkg::ST_REMAP] = (dec.action == irq_entry_pkg::ACT_REMAP);
      ev[irq_entry_pkg::ST_FAULT] = dec.fault;
    end
  end

  // ----------------------------------------------------------------
  // APB phase decode
  // ----------------------------------------------------------------

  // Setup cycle, completing access and its flavours
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign rd_status = acc & ~pwrite & hit(paddr, irq_entry_pkg::OFF_STATUS);

  // Address map membership
  assign mapped = hit(paddr, irq_entry_pkg::OFF_CTRL)
    | hit(paddr, irq_entry_pkg::OFF_STATUS)
    | hit(paddr, irq_entry_pkg::OFF_MASK)
    | hit(paddr, irq_entry_pkg::OFF_FAULT_CNT)
    | hit(paddr, irq_entry_pkg::OFF_ADDR_LO)
    | hit(paddr, irq_entry_pkg::OFF_ADDR_HI)
    | hit(paddr, irq_entry_pkg::OFF_INFO)
    | hit(paddr, irq_entry_pkg::OFF_BLOCK_CNT);

  // Control word as seen by software
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[irq_entry_pkg::CTRL_CAP_BIT] = cap_r;
    ctrl_word[irq_entry_pkg::CTRL_HAW_LO +: irq_entry_pkg::HAW_W] = haw_r;
  end

  // Strobed write values for the writable words
  assign ctrl_new = apply_strb(ctrl_word, pwdata, pstrb);
  assign mask_new = apply_strb({28'h000_0000, mask_r}, pwdata, pstrb);

  // Read multiplexer, unmapped reads give zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, irq_entry_pkg::OFF_CTRL)) begin
      rd_mux = ctrl_word;
    end else if (hit(paddr, irq_entry_pkg::OFF_STATUS)) begin
      rd_mux = {28'h000_0000, status_r};
    end else if (hit(paddr, irq_entry_pkg::OFF_MASK)) begin
      rd_mux = {28'h000_0000, mask_r};
    end else if (hit(paddr, irq_entry_pkg::OFF_FAULT_CNT)) begin
      rd_mux = {16'h0000, fault_cnt_r};
    end else if (hit(paddr, irq_entry_pkg::OFF_ADDR_LO)) begin
      rd_mux = res_r.desc_addr[31:0];
    end else if (hit(paddr, irq_entry_pkg::OFF_ADDR_HI)) begin
      rd_mux = res_r.desc_addr[63:32];
    end else if (hit(paddr, irq_entry_pkg::OFF_INFO)) begin
      rd_mux = {16'h0000, res_r.vector, 3'h0, res_r.rsv_fault,
                res_r.fault, res_r.urgent, res_r.action};
    end else if (hit(paddr, irq_entry_pkg::OFF_BLOCK_CNT)) begin
      rd_mux = {16'h0000, block_cnt_r};
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Read data and error latched during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~mapped;
    end else if (acc) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // Status bits snapped for the read, cleared only if seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_bits_r <= 4'h0;
    end else if (setup) begin
      clr_bits_r <= (!pwrite && hit(paddr, irq_entry_pkg::OFF_STATUS)) ? status_r : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Control: posting capability and host address width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= irq_entry_pkg::CTRL_RST_CAP;
      haw_r <= irq_entry_pkg::CTRL_RST_HAW;
    end else if (wr && hit(paddr, irq_entry_pkg::OFF_CTRL)) begin
      cap_r <= ctrl_new[irq_entry_pkg::CTRL_CAP_BIT];
      haw_r <= ctrl_new[irq_entry_pkg::CTRL_HAW_LO +: irq_entry_pkg::HAW_W];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= irq_entry_pkg::MASK_RST;
    end else if (wr && hit(paddr, irq_entry_pkg::OFF_MASK)) begin
      mask_r <= mask_new[3:0];
    end
  end

  // Sticky status: a new event wins over the read clear
  always_comb begin
    status_nxt = status_r;
    if (rd_status) begin
      status_nxt = status_nxt & ~clr_bits_r;
    end
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= irq_entry_pkg::STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Recorded fault counter, suppressed by the disable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_cnt_r <= 16'h0000;
    end else if (dec.valid && dec.fault && fault_cnt_r != 16'hffff) begin
      fault_cnt_r <= fault_cnt_r + 16'h0001;
    end
  end

  // Blocked request counter, counts whether or not reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_cnt_r <= 16'h0000;
    end else if (ev[irq_entry_pkg::ST_BLOCK] && block_cnt_r != 16'hffff) begin
      block_cnt_r <= block_cnt_r + 16'h0001;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign res = res_r;
  assign irq = irq_r;

endmodule // posted_irq_entry_decoder
`default_nettype wire
